// ---- shared/bats_pkg.sv ----
// package: register map, field layout, types for the trace sequencer
// assumes: one clock, apb register access, same-clock bus state input
package bats_pkg;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CMD = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_OCCUR = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_STS = 12'h010;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h014;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h018;
  // qualifier n: base + n*16, words cfg, lo, hi
  localparam logic [3:0] QUAL_PAGE = 4'h1;
  localparam int NUM_QUAL = 11;
  localparam logic [3:0] Q_STORE = 4'h0;
  localparam logic [3:0] Q_PRE = 4'h1;
  localparam logic [3:0] Q_TRIG = 4'h2;
  localparam logic [3:0] Q_WEN = 4'h3;
  localparam logic [3:0] Q_WDIS = 4'h4;
  localparam logic [3:0] Q_SEQ0 = 4'h5;
  localparam logic [2:0] MAX_SEQ = 3'h6;
  localparam logic [2:0] MAX_SEQ_WIN = 3'h3;
  localparam logic [15:0] TRACE_DEPTH = 16'h0400;
  localparam logic [15:0] TRACE_HALF = 16'h0200;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] FLD_ADDR = 2'h0;
  localparam logic [1:0] FLD_DATA = 2'h1;
  localparam logic [1:0] FLD_STAT = 2'h2;
  localparam logic [1:0] POS_AFTER = 2'h0;
  localparam logic [1:0] POS_BEFORE = 2'h1;
  localparam logic [1:0] POS_ABOUT = 2'h2;
  localparam int IRQ_TRIG = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_WOPEN = 2;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [7:0] stat;
  } bats_state_t;

  typedef struct packed {
    bats_state_t state;
    logic trig;
  } bats_word_t;

  typedef struct packed {
    logic ext;
    logic any;
    logic range;
    logic [1:0] field;
  } bats_qcfg_t;

  typedef struct packed {
    logic cmb_start_en;
    logic [2:0] seq_n;
    logic ext_rx;
    logic on_halt;
    logic repetitive;
    logic brk_on_trig;
    logic [1:0] trig_pos;
    logic trig_prog;
    logic window_en;
    logic prestore_en;
    logic store_qual_en;
  } bats_ctrl_t;

  typedef enum {ST_IDLE, ST_PRE, ST_POST, ST_DONE} bats_st_t;
endpackage : bats_pkg

// ---- verif/bats_bus_model.sv ----
// far side model: processor bus and measurement pins
// assumes: tasks are called by the bench right after a clock edge
`timescale 1ns/1ns
module bats_bus_model (
  input wire logic clk,
  output logic bus_valid,
  output bats_pkg::bats_state_t bus_state,
  output logic proc_halt,
  output logic cmb_execute,
  output logic external_arm_qualifier
);
  // ************************************************************
  // pin drivers
  // ************************************************************
  initial
  begin
    bus_valid = 1'b0;
    bus_state = 72'h0;
    proc_halt = 1'b0;
    cmb_execute = 1'b0;
    external_arm_qualifier = 1'b0;
  end
  // one bus state per cycle
  task automatic put(input bats_pkg::bats_state_t st);
    @(posedge clk);
    bus_valid <= 1'b1;
    bus_state <= st;
  endtask : put
  // released bus shows inverse of last value, no pull
  task automatic idle();
    @(posedge clk);
    bus_valid <= 1'b0;
    bus_state <= ~bus_state;
  endtask : idle
  // execute pulse, several cycles wide for the synchroniser
  task automatic exec();
    @(posedge clk);
    cmb_execute <= 1'b1;
    repeat (4) @(posedge clk);
    cmb_execute <= 1'b0;
  endtask : exec
  task automatic halt(input logic h);
    @(posedge clk);
    proc_halt <= h;
  endtask : halt
  task automatic ext(input logic e);
    @(posedge clk);
    external_arm_qualifier <= e;
  endtask : ext
endmodule : bats_bus_model

// ---- verif/tb.sv ----
// self-checking bench for the trace sequencer
// assumes: bats_top and bats_bus_model are compiled before it
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_v, v;
  logic [31:0] rng = 32'h25;
  logic pready, pslverr, rd_e, bus_valid, proc_halt, cmb_execute, ext_arm;
  logic trace_we, pre_we, break_req, irq;
  bats_pkg::bats_state_t bus_state, s;
  bats_pkg::bats_word_t trace_word, pre_word, first_word;
  int num_errors = 0;
  int comparisons = 0;
  int n_st = 0;
  int n_brk = 0;
  int n_pre = 0;
  logic [31:0] pre_addr = 32'h0;
  int exp_n;
  int ord [6] = '{2, 1, 0, 2, 1, 2};
  always #2 clk = ~clk;
  bats_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_valid(bus_valid),
    .bus_state(bus_state), .proc_halt(proc_halt),
    .cmb_execute(cmb_execute), .external_arm_qualifier(ext_arm),
    .trace_we(trace_we), .trace_word(trace_word), .pre_we(pre_we),
    .pre_word(pre_word), .break_req(break_req), .irq(irq));
  bats_bus_model bm (.clk(clk), .bus_valid(bus_valid),
    .bus_state(bus_state), .proc_halt(proc_halt),
    .cmb_execute(cmb_execute), .external_arm_qualifier(ext_arm));
  // ************************************************************
  // monitors and helpers
  // ************************************************************
  always @(posedge clk)
  begin
    if (trace_we)
    begin
      if (n_st == 0)
        first_word = trace_word;
      n_st = n_st + 1;
    end
    if (break_req)
      n_brk = n_brk + 1;
    if (pre_we)
    begin
      n_pre = n_pre + 1;
      pre_addr = pre_word.state.addr;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs
  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (i >= 20)
    begin
      num_errors++;
      test_done();
    end
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic qual(input logic [3:0] n, input logic [31:0] c, lo, hi);
    logic [11:0] b;
    b = 12'h100 + {4'h0, n, 4'h0};
    wr(b, c);
    wr(b + 12'h4, lo);
    wr(b + 12'h8, hi);
  endtask : qual
  task automatic go(input logic [31:0] c);
    wr(bats_pkg::ADDR_CMD, 32'h2);
    wr(bats_pkg::ADDR_CTRL, c);
    n_st = 0;
    n_brk = 0;
    n_pre = 0;
    wr(bats_pkg::ADDR_CMD, 32'h1);
  endtask : go
  task automatic put_rand(input logic [31:0] a);
    rng = xs(rng);
    bm.put({a, rng, rng[7:0]});
  endtask : put_rand
  task automatic burst(input logic [31:0] a, input int n);
    for (int i = 0; i < n; i++)
      put_rand(a + i);
    bm.idle();
    repeat (3) @(posedge clk);
  endtask : burst
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(bats_pkg::ADDR_CTRL);
    check("ctrl_rst", rd_v, bats_pkg::CTRL_RESET);
    rd(bats_pkg::ADDR_OCCUR);
    check("occur_rst", rd_v, 32'h0);
    rd(bats_pkg::ADDR_STATUS);
    check("status_rst", rd_v, 32'h0);
    rng = xs(rng);
    wr(bats_pkg::ADDR_CTRL, rng & 32'h3fff);
    rd(bats_pkg::ADDR_CTRL);
    check("ctrl_rw", rd_v, rng & 32'h3fff);
    rd(12'hffc);
    check("unmapped_err", rd_e, 1'b1);
    check("unmapped_rd", rd_v, 32'h0);
    wr(bats_pkg::ADDR_IRQ_EN, 32'h2);
    go(32'h0);
    burst(32'h5000, 1030);
    check("stored_all", n_st, 1024);
    check("trig_first", first_word.trig, 1'b1);
    check("trig_addr", first_word.state.addr, 32'h5000);
    rd(bats_pkg::ADDR_STATUS);
    check("done", rd_v[1], 1'b1);
    check("irq_done", irq, 1'b1);
    wr(bats_pkg::ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    check("irq_mask", irq, 1'b0);
    wr(bats_pkg::ADDR_IRQ_CLR, 32'h2);
    rd(bats_pkg::ADDR_IRQ_STS);
    check("irq_clr", rd_v[1], 1'b0);
    for (int f = 0; f < 3; f++)
    begin
      qual(bats_pkg::Q_STORE, 32'h4 | f, 32'h14, 32'h18);
      go(32'h1);
      exp_n = 0;
      for (int i = 0; i < 40; i++)
      begin
        rng = xs(rng);
        v = (i == 0) ? 32'h14 : 32'h10 + rng % 12;
        s = {rng, ~rng, rng[15:8]};
        if (f == 0)
          s.addr = v;
        else if (f == 1)
          s.data = v;
        else
          s.stat = v[7:0];
        if (v >= 32'h14 && v <= 32'h18)
          exp_n++;
        bm.put(s);
      end
      bm.idle();
      repeat (3) @(posedge clk);
      check("qual_store", n_st, exp_n);
    end
    qual(bats_pkg::Q_TRIG, 32'h0, 32'h2000, 32'h0);
    wr(bats_pkg::ADDR_OCCUR, 32'h2);
    go(32'h48);
    burst(32'h2000, 1);
    burst(32'h2004, 1);
    check("brk_first", n_brk, 0);
    burst(32'h2000, 1);
    check("brk_second", n_brk, 1);
    check("after_trig", first_word.trig, 1'b1);
    check("after_addr", first_word.state.addr, 32'h2000);
    check("after_cnt", n_st, 1);
    wr(bats_pkg::ADDR_OCCUR, 32'h1);
    qual(bats_pkg::Q_SEQ0, 32'h0, 32'ha00, 32'h0);
    qual(bats_pkg::Q_SEQ0 + 4'h1, 32'h0, 32'ha01, 32'h0);
    qual(bats_pkg::Q_TRIG, 32'h0, 32'ha02, 32'h0);
    go(32'h808);
    for (int i = 0; i < 6; i++)
      burst(32'ha00 + ord[i], 1);
    check("seq_cnt", n_st, 1);
    check("seq_addr", first_word.state.addr, 32'ha02);
    qual(bats_pkg::Q_TRIG, 32'h0, 32'hb00, 32'h0);
    go(32'h18);
    burst(32'hc00, 5);
    burst(32'hb00, 1);
    burst(32'hc10, 5);
    check("before_cnt", n_st, 6);
    check("before_trig", first_word.trig, 1'b0);
    wr(bats_pkg::ADDR_CMD, 32'h2);
    wr(bats_pkg::ADDR_CTRL, 32'h2000);
    bm.exec();
    repeat (4) @(posedge clk);
    rd(bats_pkg::ADDR_STATUS);
    check("exec_busy", rd_v[0], 1'b1);
    qual(bats_pkg::Q_WEN, 32'h0, 32'h3000, 32'h0);
    qual(bats_pkg::Q_WDIS, 32'h0, 32'h3001, 32'h0);
    go(32'h4);
    burst(32'h100, 4);
    check("win_closed", n_st, 0);
    burst(32'h3000, 1);
    burst(32'h200, 5);
    burst(32'h3001, 1);
    burst(32'h300, 4);
    check("win_open", n_st, 5);
    rd(bats_pkg::ADDR_IRQ_STS);
    check("win_irq", rd_v[2], 1'b1);
    go(32'h100);
    burst(32'h600, 3);
    bm.halt(1'b1);
    repeat (2) @(posedge clk);
    burst(32'h700, 3);
    check("halt_stop", n_st, 3);
    bm.halt(1'b0);
    qual(bats_pkg::Q_STORE, 32'h18, 32'h0, 32'h0);
    bm.ext(1'b1);
    go(32'h201);
    burst(32'h800, 4);
    bm.ext(1'b0);
    repeat (4) @(posedge clk);
    burst(32'h900, 4);
    check("ext_qual", n_st, 4);
    qual(bats_pkg::Q_STORE, 32'h0, 32'h20, 32'h0);
    qual(bats_pkg::Q_PRE, 32'h0, 32'h1f, 32'h0);
    go(32'h3);
    burst(32'h40, 1);
    burst(32'h1f, 2);
    check("pre_cnt", n_pre, 1);
    check("pre_addr", pre_addr, 32'h1f);
    check("pre_store", n_st, 2);
    go(32'ha0);
    burst(32'h7000, 520);
    check("about_cnt", n_st, 512);
    n_st = 0;
    wr(bats_pkg::ADDR_CMD, 32'h4);
    burst(32'h7100, 1);
    check("rep_restart", n_st, 1);
    test_done();
  end
endmodule : tb

// ---- verilog/bats_top.sv ----
// file: trace sequencer core with apb register slave
// assumes: bus state arrives on clk; cmb execute and external trigger
// are asynchronous pins
`timescale 1ns/1ns

// How it works
// - without storage qualifier every recognized state is stored, except states before the trigger in after position
// - rising coordinated execute pin starts acquisition
// - break-at-trigger pulses break request on trigger
// - on-halt stores until halt or stop; no trigger, break, repeat
// - with store qualifier only matching states and the trigger state are written
// - prestore keeps selected state preceding each stored state
// - repetitive mode restarts after trace delivered until stop
// - up to six sequence terms matched in order, then trigger
// - windowing limits sequence to three terms plus trigger
// - trigger position after, before or centred
// - trigger fires after programmed number of occurrences
// - no trigger programmed means trigger on first state
// - closed window: no storing, only enable term searched
// - disable term closes window, stops storing and sequencing
// - one enable and one disable term; no window means all seen
// - qualifiers match address, data or status, value or range
// - external trigger line usable as qualifier when received
module bats_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_valid,
  input wire bats_pkg::bats_state_t bus_state,
  input wire logic proc_halt,
  input wire logic cmb_execute,
  input wire logic external_arm_qualifier,
  output logic trace_we,
  output bats_pkg::bats_word_t trace_word,
  output logic pre_we,
  output bats_pkg::bats_word_t pre_word,
  output logic break_req,
  output logic irq
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [1:0] exe_ff, ext_ff;
  logic exe_d_ff;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      exe_ff <= 2'h0;
      ext_ff <= 2'h0;
      exe_d_ff <= 1'b0;
    end
    else
    begin
      exe_ff <= {exe_ff[0], cmb_execute};
      ext_ff <= {ext_ff[0], external_arm_qualifier};
      exe_d_ff <= exe_ff[1];
    end
  end
  logic exe_rise;
  assign exe_rise = exe_ff[1] & ~exe_d_ff;

  // ****************************************************************
  // qualifier match
  // ****************************************************************
  function automatic logic qmatch(input bats_pkg::bats_qcfg_t c,
    input logic [31:0] lo, input logic [31:0] hi,
    input bats_pkg::bats_state_t s, input logic ext);
    logic [31:0] v;
    logic m;
    v = s.addr;
    if (c.field == bats_pkg::FLD_DATA)
      v = s.data;
    else if (c.field == bats_pkg::FLD_STAT)
      v = {24'h0, s.stat};
    m = c.range ? (v >= lo && v <= hi) : (v == lo);
    qmatch = (c.any | m) & (~c.ext | ext);
  endfunction : qmatch

  // ****************************************************************
  // registers and apb slave
  // ****************************************************************
  bats_pkg::bats_ctrl_t ctrl_ff, nxt_ctrl;
  bats_pkg::bats_qcfg_t qcfg_ff [bats_pkg::NUM_QUAL];
  bats_pkg::bats_qcfg_t nxt_qcfg [bats_pkg::NUM_QUAL];
  logic [31:0] qlo_ff [bats_pkg::NUM_QUAL];
  logic [31:0] nxt_qlo [bats_pkg::NUM_QUAL];
  logic [31:0] qhi_ff [bats_pkg::NUM_QUAL];
  logic [31:0] nxt_qhi [bats_pkg::NUM_QUAL];
  logic [15:0] occ_ff, nxt_occ;
  logic [2:0] ien_ff, nxt_ien, ists_ff, nxt_ists, iset;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic cmd_start, cmd_stop, cmd_deliv;
  logic irq_ff;
  bats_pkg::bats_st_t st_ff;
  logic [2:0] lvl_ff;
  logic win_ff;

  logic acc, wr_done, is_q, qok;
  logic [3:0] qi;
  assign acc = psel & penable & ~pready_ff;
  assign wr_done = psel & penable & pready_ff & pwrite & ~pslverr_ff;
  assign is_q = paddr[11:8] == bats_pkg::QUAL_PAGE;
  assign qi = paddr[7:4];
  assign qok = is_q && 32'(qi) < bats_pkg::NUM_QUAL && paddr[3:2] != 2'h3;

  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_occ = occ_ff;
    nxt_ien = ien_ff;
    nxt_qcfg = qcfg_ff;
    nxt_qlo = qlo_ff;
    nxt_qhi = qhi_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata = 32'h0;
    cmd_start = 1'b0;
    cmd_stop = 1'b0;
    cmd_deliv = 1'b0;
    nxt_ists = (ists_ff | iset);
    if (acc)
    begin
      nxt_pready = 1'b1;
      case (paddr)
        bats_pkg::ADDR_CTRL: nxt_prdata = {18'h0, ctrl_ff};
        bats_pkg::ADDR_CMD: nxt_prdata = 32'h0;
        bats_pkg::ADDR_STATUS:
          nxt_prdata = {26'h0, win_ff, lvl_ff, st_ff == bats_pkg::ST_DONE,
            st_ff != bats_pkg::ST_IDLE};
        bats_pkg::ADDR_OCCUR: nxt_prdata = {16'h0, occ_ff};
        bats_pkg::ADDR_IRQ_STS: nxt_prdata = {29'h0, ists_ff};
        bats_pkg::ADDR_IRQ_EN: nxt_prdata = {29'h0, ien_ff};
        bats_pkg::ADDR_IRQ_CLR: nxt_prdata = 32'h0;
        default:
        begin
          nxt_pslverr = ~qok;
          if (qok)
          begin
            case (paddr[3:2])
              2'h0: nxt_prdata = {27'h0, qcfg_ff[qi]};
              2'h1: nxt_prdata = qlo_ff[qi];
              default: nxt_prdata = qhi_ff[qi];
            endcase
          end
        end
      endcase
    end
    if (wr_done)
    begin
      case (paddr)
        bats_pkg::ADDR_CTRL: nxt_ctrl = pwdata[13:0];
        bats_pkg::ADDR_CMD:
        begin
          cmd_start = pwdata[0];
          cmd_stop = pwdata[1];
          cmd_deliv = pwdata[2];
        end
        bats_pkg::ADDR_OCCUR: nxt_occ = pwdata[15:0];
        bats_pkg::ADDR_IRQ_EN: nxt_ien = pwdata[2:0];
        bats_pkg::ADDR_IRQ_CLR: nxt_ists = (ists_ff & ~pwdata[2:0]) | iset;
        default:
        begin
          if (qok)
          begin
            case (paddr[3:2])
              2'h0: nxt_qcfg[qi] = pwdata[4:0];
              2'h1: nxt_qlo[qi] = pwdata;
              default: nxt_qhi[qi] = pwdata;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_ff <= bats_pkg::CTRL_RESET[13:0];
      occ_ff <= 16'h0;
      ien_ff <= 3'h0;
      ists_ff <= 3'h0;
      irq_ff <= 1'b0;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      for (int i = 0; i < bats_pkg::NUM_QUAL; i++)
      begin
        qcfg_ff[i] <= 5'h0;
        qlo_ff[i] <= 32'h0;
        qhi_ff[i] <= 32'h0;
      end
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      occ_ff <= nxt_occ;
      ien_ff <= nxt_ien;
      ists_ff <= nxt_ists;
      irq_ff <= |(nxt_ists & nxt_ien);
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      qcfg_ff <= nxt_qcfg;
      qlo_ff <= nxt_qlo;
      qhi_ff <= nxt_qhi;
    end
  end

  // ****************************************************************
  // sequencer engine
  // ****************************************************************
  bats_pkg::bats_st_t nxt_st;
  logic [2:0] nxt_lvl, seq_eff;
  logic [15:0] cnt_ff, nxt_cnt, hits_ff, nxt_hits;
  logic nxt_win, pv_ff, nxt_pv, nxt_we, nxt_pwe, nxt_brk, we_ff;
  logic pwe_ff, brk_ff;
  bats_pkg::bats_word_t word_ff, nxt_word, pw_ff, nxt_pw;
  logic ext, rec, m_st, m_pre, m_trig, m_en, m_dis, m_seq, sto, fire;
  logic halt_mode, rep_mode, brk_mode;
  logic [15:0] occ_need;
  logic [3:0] seq_idx;

  assign ext = ext_ff[1] & ctrl_ff.ext_rx;
  assign halt_mode = ctrl_ff.on_halt;
  assign rep_mode = ctrl_ff.repetitive & ~halt_mode;
  assign brk_mode = ctrl_ff.brk_on_trig & ~halt_mode;
  assign seq_idx = bats_pkg::Q_SEQ0 + {1'b0, lvl_ff};
  assign occ_need = (occ_ff == 16'h0) ? 16'h1 : occ_ff;

  always_comb
  begin
    seq_eff = ctrl_ff.seq_n > bats_pkg::MAX_SEQ ? bats_pkg::MAX_SEQ
      : ctrl_ff.seq_n;
    if (ctrl_ff.window_en && seq_eff > bats_pkg::MAX_SEQ_WIN)
      seq_eff = bats_pkg::MAX_SEQ_WIN;
  end

  always_comb
  begin
    m_st = qmatch(qcfg_ff[bats_pkg::Q_STORE], qlo_ff[bats_pkg::Q_STORE],
      qhi_ff[bats_pkg::Q_STORE], bus_state, ext);
    m_pre = qmatch(qcfg_ff[bats_pkg::Q_PRE], qlo_ff[bats_pkg::Q_PRE],
      qhi_ff[bats_pkg::Q_PRE], bus_state, ext);
    m_trig = qmatch(qcfg_ff[bats_pkg::Q_TRIG], qlo_ff[bats_pkg::Q_TRIG],
      qhi_ff[bats_pkg::Q_TRIG], bus_state, ext);
    m_en = qmatch(qcfg_ff[bats_pkg::Q_WEN], qlo_ff[bats_pkg::Q_WEN],
      qhi_ff[bats_pkg::Q_WEN], bus_state, ext);
    m_dis = qmatch(qcfg_ff[bats_pkg::Q_WDIS], qlo_ff[bats_pkg::Q_WDIS],
      qhi_ff[bats_pkg::Q_WDIS], bus_state, ext);
    m_seq = 1'b0;
    if (32'(seq_idx) < bats_pkg::NUM_QUAL)
      m_seq = qmatch(qcfg_ff[seq_idx], qlo_ff[seq_idx], qhi_ff[seq_idx],
        bus_state, ext);
  end

  always_comb
  begin
    nxt_st = st_ff;
    nxt_lvl = lvl_ff;
    nxt_cnt = cnt_ff;
    nxt_hits = hits_ff;
    nxt_win = win_ff;
    nxt_pv = pv_ff;
    nxt_pw = pw_ff;
    nxt_we = 1'b0;
    nxt_pwe = 1'b0;
    nxt_brk = 1'b0;
    nxt_word = word_ff;
    iset = 3'h0;
    rec = 1'b0;
    sto = 1'b0;
    fire = 1'b0;
    if (bus_valid && (st_ff == bats_pkg::ST_PRE || st_ff == bats_pkg::ST_POST))
    begin
      if (!ctrl_ff.window_en)
        rec = 1'b1;
      else if (!win_ff)
      begin
        nxt_win = m_en;
        iset[bats_pkg::IRQ_WOPEN] = m_en;
      end
      else if (m_dis)
        nxt_win = 1'b0;
      else
        rec = 1'b1;
      sto = rec & (~ctrl_ff.store_qual_en | m_st);
      if (rec && st_ff == bats_pkg::ST_PRE && !halt_mode)
      begin
        if (lvl_ff < seq_eff)
        begin
          if (m_seq)
            nxt_lvl = lvl_ff + 3'h1;
        end
        else if (!ctrl_ff.trig_prog || m_trig)
        begin
          nxt_hits = hits_ff + 16'h1;
          fire = ~ctrl_ff.trig_prog | (nxt_hits >= occ_need);
        end
      end
      if (st_ff == bats_pkg::ST_PRE && !fire
        && ctrl_ff.trig_pos == bats_pkg::POS_AFTER && !halt_mode)
        sto = 1'b0;
      sto = sto | fire;
      if (rec && !sto && ctrl_ff.prestore_en && m_pre)
      begin
        nxt_pv = 1'b1;
        nxt_pw = {bus_state, 1'b0};
      end
      if (sto)
      begin
        nxt_we = 1'b1;
        nxt_word = {bus_state, fire};
        nxt_pwe = pv_ff;
        nxt_pv = 1'b0;
      end
      if (fire)
      begin
        iset[bats_pkg::IRQ_TRIG] = 1'b1;
        nxt_brk = brk_mode;
        case (ctrl_ff.trig_pos)
          bats_pkg::POS_BEFORE: nxt_st = bats_pkg::ST_DONE;
          bats_pkg::POS_ABOUT:
          begin
            nxt_st = bats_pkg::ST_POST;
            nxt_cnt = bats_pkg::TRACE_HALF - 16'h1;
          end
          default:
          begin
            nxt_st = bats_pkg::ST_POST;
            nxt_cnt = bats_pkg::TRACE_DEPTH - 16'h1;
          end
        endcase
      end
      else if (st_ff == bats_pkg::ST_POST && sto)
      begin
        nxt_cnt = cnt_ff - 16'h1;
        if (cnt_ff == 16'h1)
          nxt_st = bats_pkg::ST_DONE;
      end
    end
    if (halt_mode && st_ff == bats_pkg::ST_PRE && proc_halt)
      nxt_st = bats_pkg::ST_DONE;
    if (nxt_st == bats_pkg::ST_DONE && st_ff != bats_pkg::ST_DONE)
      iset[bats_pkg::IRQ_DONE] = 1'b1;
    if (st_ff == bats_pkg::ST_DONE && cmd_deliv && rep_mode)
      nxt_st = bats_pkg::ST_PRE;
    if (cmd_start
      || (exe_rise && ctrl_ff.cmb_start_en))
      nxt_st = bats_pkg::ST_PRE;
    if (cmd_stop)
      nxt_st = bats_pkg::ST_IDLE;
    if (nxt_st == bats_pkg::ST_PRE && st_ff != bats_pkg::ST_PRE)
    begin
      nxt_lvl = 3'h0;
      nxt_hits = 16'h0;
      nxt_win = 1'b0;
      nxt_pv = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_ff <= bats_pkg::ST_IDLE;
      lvl_ff <= 3'h0;
      cnt_ff <= 16'h0;
      hits_ff <= 16'h0;
      win_ff <= 1'b0;
      pv_ff <= 1'b0;
      pw_ff <= '0;
      we_ff <= 1'b0;
      pwe_ff <= 1'b0;
      brk_ff <= 1'b0;
      word_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
      lvl_ff <= nxt_lvl;
      cnt_ff <= nxt_cnt;
      hits_ff <= nxt_hits;
      win_ff <= nxt_win;
      pv_ff <= nxt_pv;
      pw_ff <= nxt_pw;
      we_ff <= nxt_we;
      pwe_ff <= nxt_pwe;
      brk_ff <= nxt_brk;
      word_ff <= nxt_word;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign trace_we = we_ff;
  assign trace_word = word_ff;
  assign pre_we = pwe_ff;
  assign pre_word = pw_ff;
  assign break_req = brk_ff;
  assign irq = irq_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  no_filter_a: assert property (
    st_ff == bats_pkg::ST_POST && bus_valid && !ctrl_ff.window_en
    && !ctrl_ff.store_qual_en && !cmd_stop |=> we_ff)
    else $error("unqualified state not stored");
  qual_only_a: assert property (
    we_ff && !word_ff.trig && $past(ctrl_ff.store_qual_en) |->
    $past(m_st)) else $error("non-matching state stored");
  cmb_start_a: assert property (
    exe_rise && ctrl_ff.cmb_start_en && !cmd_stop |=>
    st_ff == bats_pkg::ST_PRE) else $error("execute did not start");
  brk_trig_a: assert property (
    brk_ff |-> word_ff.trig && we_ff) else $error("break without trigger");
  halt_stop_a: assert property (
    halt_mode && st_ff == bats_pkg::ST_PRE && proc_halt && !cmd_start
    && !(exe_rise && ctrl_ff.cmb_start_en) && !cmd_stop |=>
    st_ff == bats_pkg::ST_DONE ##1 !brk_ff) else $error("halt ignored");
  pre_pair_a: assert property (
    pwe_ff |-> we_ff) else $error("prestore without stored state");
  seq_limit_a: assert property (
    ctrl_ff.window_en && st_ff == bats_pkg::ST_PRE |->
    lvl_ff <= bats_pkg::MAX_SEQ_WIN) else $error("window seq over limit");
  before_done_a: assert property (
    we_ff && word_ff.trig && $past(ctrl_ff.trig_pos) == bats_pkg::POS_BEFORE
    |-> st_ff == bats_pkg::ST_DONE) else $error("before kept running");
  occ_a: assert property (
    we_ff && word_ff.trig && $past(ctrl_ff.trig_prog) |->
    hits_ff >= $past(occ_need)) else $error("trigger before count");
  win_closed_a: assert property (
    ctrl_ff.window_en && !win_ff && !cmd_start |=> !we_ff
    && $stable(lvl_ff)) else $error("closed window active");
  irq_a: assert property (
    irq_ff == |(ists_ff & ien_ff)) else $error("irq not status level");
  rep_restart_a: assert property (
    st_ff == bats_pkg::ST_DONE && cmd_deliv && rep_mode && !cmd_stop |=>
    st_ff == bats_pkg::ST_PRE) else $error("no repetitive restart");

  trig_c: cover property (we_ff && word_ff.trig);
  rep_c: cover property (st_ff == bats_pkg::ST_DONE && cmd_deliv
    && rep_mode);
  win_c: cover property (win_ff ##1 !win_ff);
  pre_c: cover property (pwe_ff);
endmodule : bats_top
